/* verilog/epiu_pkg.sv */
// constants, register map and bus carrier of the external pin interrupt unit
// assumes one 125 MHz clock and an avalon-mm master with 32-bit data
// Overview of operation
// - any masked upper pin-change toggle raises the upper group request
// - any masked lower pin-change toggle raises the lower group request
// - pins are watched whatever their direction, so writes can self-interrupt
// - pin-change detection on all sixteen inputs is meant to wake from sleep
// - two-bit sense select: low level, any change, falling, rising
// - enabled level sensing keeps requesting while the pin stays low
// - edges are found on the sampled pin value, needing the clock
// - edge or change pulses longer than one clock period are caught
// - level wake-up gives no interrupt if the level vanishes early
// - per-input enable bits; service needs enable and global bit
// - matching edge or change sets the input flag; flag requests vector
// - input flag clears on vector entry or by writing one
// - input flag reads cleared while its input senses low level
// - per-group enable bits; group serviced needs enable and global bit
// - each pin joins its group request through its own mask bit
// - unused upper register bits read as zero
// - sense register: input one in bits 3:2, zero in 1:0, reset clear
// - low-level detection is meant to work with the clock stopped
// - group request sets group flag; clears on vector entry or write one
package epiu_pkg;
  localparam int unsigned EPIU_ADDR_W = 9;
  localparam int unsigned EPIU_IDX_W = 7;
  // register indices; byte address is four times the index
  localparam logic [6:0] EPIU_IDX_SENSE = 7'h69;
  localparam logic [6:0] EPIU_IDX_MASK_LO = 7'h6B;
  localparam logic [6:0] EPIU_IDX_MASK_HI = 7'h6C;
  localparam logic [6:0] EPIU_IDX_EXT_EN = 7'h6D;
  localparam logic [6:0] EPIU_IDX_EXT_FLAG = 7'h6E;
  localparam logic [6:0] EPIU_IDX_PC_CTRL = 7'h6F;
  localparam logic [6:0] EPIU_IDX_PC_FLAG = 7'h70;
  localparam int unsigned EPIU_SEL_ZERO_LSB = 0;
  localparam int unsigned EPIU_SEL_ONE_LSB = 2;
  localparam logic [3:0] EPIU_SENSE_RST = 4'h0;
  localparam logic [1:0] EPIU_EN_RST = 2'h0;
  localparam logic [7:0] EPIU_MASK_RST = 8'h00;
  // sense encodings
  localparam logic [1:0] EPIU_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPIU_SENSE_ANY = 2'h1;
  localparam logic [1:0] EPIU_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPIU_SENSE_RISE = 2'h3;
  // request line order
  localparam int unsigned EPIU_SRC_EXT0 = 0;
  localparam int unsigned EPIU_SRC_EXT1 = 1;
  localparam int unsigned EPIU_SRC_PC_LO = 2;
  localparam int unsigned EPIU_SRC_PC_HI = 3;
  // cycles after reset before pin history is trusted
  localparam logic [1:0] EPIU_WARM_CYCLES = 2'h3;

  typedef struct packed {
    logic read;
    logic write;
    logic [EPIU_ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } epiu_avs_req_t;
endpackage

/* verilog/epiu_top.sv */
// external pin interrupt unit: two sensed inputs, two pin-change groups
// assumes pins are asynchronous and cpu signals share mclk_i
`timescale 1ns/1ns
module epiu_top #(
  parameter int unsigned GROUP_W = 8
) (
  input wire logic mclk_i, // 125 MHz clock
  input wire logic reset_i, // sync reset, high
  input wire epiu_pkg::epiu_avs_req_t avs_i, // avalon request
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // slave busy
  input wire logic ext_irq_in_zero_i, // sensed input zero
  input wire logic ext_irq_in_one_i, // sensed input one
  input wire logic [2*GROUP_W-1:0] pin_change_inputs_i, // change pins
  input wire logic global_int_en_i, // cpu global enable
  input wire logic [3:0] irq_ack_i, // vector entry pulses
  output logic [3:0] irq_req_o, // request per source
  output logic wake_o // wake-up request
);

  if (GROUP_W < 1 || GROUP_W > 8) begin : g_bad_width
    $error("GROUP_W must be 1 to 8");
  end

  function automatic logic sense_hit(input logic [1:0] sel,
                                     input logic cur,
                                     input logic prev);
    case (sel)
      epiu_pkg::EPIU_SENSE_ANY: return cur ^ prev;
      epiu_pkg::EPIU_SENSE_FALL: return prev & ~cur;
      epiu_pkg::EPIU_SENSE_RISE: return ~prev & cur;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic reg_hit(
    input logic [epiu_pkg::EPIU_ADDR_W-1:0] addr,
    input logic [epiu_pkg::EPIU_IDX_W-1:0] idx);
    return addr[epiu_pkg::EPIU_ADDR_W-1:2] == idx;
  endfunction

  logic [1:0] ext_meta;
  logic [1:0] ext_sync;
  logic [1:0] ext_prev;
  logic [2*GROUP_W-1:0] pc_meta;
  logic [2*GROUP_W-1:0] pc_sync;
  logic [2*GROUP_W-1:0] pc_prev;
  logic [1:0] warm_cnt;
  logic warm;
  logic [3:0] sense;
  logic [1:0] ext_en;
  logic [1:0] ext_flag;
  logic [1:0] pc_en;
  logic [1:0] pc_flag;
  logic [1:0][GROUP_W-1:0] pc_mask;
  logic [1:0] ext_set;
  logic [1:0] ext_clr;
  logic [1:0] ext_lvl;
  logic [1:0] pc_set;
  logic [1:0] pc_clr;
  logic [3:0] next_irq;
  logic next_wake;
  logic bus_req;
  logic wr_go;
  logic [7:0] wdat;
  logic [7:0] rd_byte;

  // pins sampled whatever their direction, two stages before use
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ext_meta <= 2'h0;
      ext_sync <= 2'h0;
      ext_prev <= 2'h0;
      pc_meta <= '0;
      pc_sync <= '0;
      pc_prev <= '0;
    end else begin
      ext_meta <= {ext_irq_in_one_i, ext_irq_in_zero_i};
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      pc_meta <= pin_change_inputs_i;
      pc_sync <= pc_meta;
      pc_prev <= pc_sync;
    end
  end

  // history flops start at zero; no events until they hold real pin values
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      warm_cnt <= 2'h0;
    end else if (warm_cnt != epiu_pkg::EPIU_WARM_CYCLES) begin
      warm_cnt <= warm_cnt + 2'h1;
    end
  end
  assign warm = (warm_cnt == epiu_pkg::EPIU_WARM_CYCLES);

  // bus: each request answered after one wait cycle
  assign bus_req = avs_i.read | avs_i.write;
  assign wr_go = avs_i.write & ~avs_waitrequest_o & avs_i.byteenable[0];
  assign wdat = avs_i.writedata[7:0];

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sense <= epiu_pkg::EPIU_SENSE_RST;
    end else if (wr_go && reg_hit(avs_i.address,
                                  epiu_pkg::EPIU_IDX_SENSE)) begin
      sense <= wdat[3:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ext_en <= epiu_pkg::EPIU_EN_RST;
    end else if (wr_go && reg_hit(avs_i.address,
                                  epiu_pkg::EPIU_IDX_EXT_EN)) begin
      ext_en <= wdat[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pc_en <= epiu_pkg::EPIU_EN_RST;
    end else if (wr_go && reg_hit(avs_i.address,
                                  epiu_pkg::EPIU_IDX_PC_CTRL)) begin
      pc_en <= wdat[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pc_mask[0] <= epiu_pkg::EPIU_MASK_RST[GROUP_W-1:0];
      pc_mask[1] <= epiu_pkg::EPIU_MASK_RST[GROUP_W-1:0];
    end else if (wr_go) begin
      if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_MASK_LO)) begin
        pc_mask[0] <= wdat[GROUP_W-1:0];
      end
      if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_MASK_HI)) begin
        pc_mask[1] <= wdat[GROUP_W-1:0];
      end
    end
  end

  // sensed inputs: edge flags, or a plain level request
  for (genvar i = 0; i < 2; i++) begin : g_ext
    logic [1:0] sel;
    // field position from the package, so the map lives in one place
    assign sel = (i == 0) ? sense[epiu_pkg::EPIU_SEL_ZERO_LSB +: 2] :
                            sense[epiu_pkg::EPIU_SEL_ONE_LSB +: 2];
    assign ext_lvl[i] = (sel == epiu_pkg::EPIU_SENSE_LOW);
    // the sampled level must stand one edge, so pulses over a period hit
    assign ext_set[i] = warm & sense_hit(sel, ext_sync[i],
                                         ext_prev[i]);
    assign ext_clr[i] = irq_ack_i[i] |
      (wr_go & reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_EXT_FLAG) &
       wdat[i]);

    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        ext_flag[i] <= 1'b0;
      end else if (ext_lvl[i]) begin
        ext_flag[i] <= 1'b0;
      end else if (ext_set[i]) begin
        ext_flag[i] <= 1'b1;
      end else if (ext_clr[i]) begin
        ext_flag[i] <= 1'b0;
      end
    end

    // a level request lasts only while the pin is low
    assign next_irq[i] = ext_en[i] & global_int_en_i &
      (ext_lvl[i] ? ~ext_sync[i] : ext_flag[i]);

    sequence s_rise_seen;
      !ext_sync[i] ##1 (warm && ext_sync[i] &&
                        sel == epiu_pkg::EPIU_SENSE_RISE);
    endsequence

    // vector entry, then a quiet cycle with no new event
    sequence s_ack_taken;
      (irq_ack_i[i] && !ext_set[i] && !ext_lvl[i]) ##1
      (!ext_set[i] && !ext_lvl[i]);
    endsequence

    a_fall_sets: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (warm && sel == epiu_pkg::EPIU_SENSE_FALL && ext_prev[i] &&
       !ext_sync[i]) |=> ext_flag[i])
      else $error("falling edge did not set flag");
    a_rise_sets: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (warm && sel == epiu_pkg::EPIU_SENSE_RISE && !ext_prev[i] &&
       ext_sync[i]) |=> ext_flag[i])
      else $error("rising edge did not set flag");
    a_rise_path: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      s_rise_seen |=> ext_flag[i])
      else $error("rise on the sampled pin did not set flag");
    a_level_zero: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      ext_lvl[i] |=> !ext_flag[i])
      else $error("flag set in level mode");
    a_level_read: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (avs_i.read && avs_waitrequest_o && ext_lvl[i] &&
       reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_EXT_FLAG))
      |=> !avs_readdata_o[i])
      else $error("flag read as set in level mode");
    a_level_req: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (ext_lvl[i] && ext_en[i] && global_int_en_i && !ext_sync[i])
      |=> irq_req_o[i])
      else $error("low level not requesting");
    a_level_idle: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (ext_lvl[i] && ext_sync[i]) |=> !irq_req_o[i])
      else $error("high level still requesting");
    a_en_gates: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !ext_en[i] |=> !irq_req_o[i])
      else $error("request with input enable off");
    a_flag_quiet: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (!ext_set[i] && !ext_flag[i]) |=> !ext_flag[i])
      else $error("flag set with no matching event");
    a_ack_clears: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (ext_flag[i] && irq_ack_i[i] && !ext_set[i]) |=> !ext_flag[i])
      else $error("acknowledge did not clear flag");
    a_w1c_clears: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (wr_go && wdat[i] && !ext_set[i] &&
       reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_EXT_FLAG))
      |=> !ext_flag[i])
      else $error("write of one did not clear flag");
    a_ack_drops: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      s_ack_taken |=> !irq_req_o[i])
      else $error("request stayed up after acknowledge");
  end

  // pin-change groups: any masked toggle sets the group flag
  for (genvar g = 0; g < 2; g++) begin : g_pc
    logic [GROUP_W-1:0] chg;
    assign chg = pc_sync[g*GROUP_W +: GROUP_W] ^
                 pc_prev[g*GROUP_W +: GROUP_W];
    assign pc_set[g] = warm & |(chg & pc_mask[g]);
    assign pc_clr[g] = irq_ack_i[epiu_pkg::EPIU_SRC_PC_LO + g] |
      (wr_go & reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_PC_FLAG) &
       wdat[g]);

    // set beats clear so a toggle in the clearing cycle is kept
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        pc_flag[g] <= 1'b0;
      end else if (pc_set[g]) begin
        pc_flag[g] <= 1'b1;
      end else if (pc_clr[g]) begin
        pc_flag[g] <= 1'b0;
      end
    end

    assign next_irq[epiu_pkg::EPIU_SRC_PC_LO + g] =
      pc_en[g] & global_int_en_i & pc_flag[g];

    sequence s_grp_hit;
      (pc_set[g] && pc_en[g] && global_int_en_i) ##1
      (pc_en[g] && global_int_en_i);
    endsequence

    a_group_sets: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (warm && |(chg & pc_mask[g])) |=> pc_flag[g])
      else $error("masked toggle did not set group flag");
    a_group_quiet: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (!(|(chg & pc_mask[g])) && !pc_flag[g]) |=> !pc_flag[g])
      else $error("group flag set with no masked toggle");
    a_set_wins: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (pc_set[g] && pc_clr[g]) |=> pc_flag[g])
      else $error("clear beat a same-cycle change");
    a_group_clears: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (pc_flag[g] && pc_clr[g] && !pc_set[g]) |=> !pc_flag[g])
      else $error("group flag not cleared");
    a_group_gated: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      !pc_en[g] |=> !irq_req_o[epiu_pkg::EPIU_SRC_PC_LO + g])
      else $error("group request with group enable off");
    a_group_path: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      s_grp_hit |=> irq_req_o[epiu_pkg::EPIU_SRC_PC_LO + g])
      else $error("group request missing");
  end

  // wake ignores the global bit; the clock here never stops, so this
  // stands in for the clockless detector of a sleeping part
  assign next_wake = |(ext_en & ext_lvl & ~ext_sync) |
                     |(ext_en & ext_flag) | |(pc_en & pc_flag);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_req_o <= 4'h0;
      wake_o <= 1'b0;
    end else begin
      irq_req_o <= next_irq;
      wake_o <= next_wake;
    end
  end

  // readback; unused upper bits and unmapped words are zero
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_SENSE)) begin
      rd_byte = {4'h0, sense};
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_EXT_EN)) begin
      rd_byte = {6'h00, ext_en};
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_EXT_FLAG)) begin
      rd_byte = {6'h00, ext_flag & ~ext_lvl};
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_PC_CTRL)) begin
      rd_byte = {6'h00, pc_en};
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_PC_FLAG)) begin
      rd_byte = {6'h00, pc_flag};
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_MASK_LO)) begin
      rd_byte = 8'(pc_mask[0]);
    end else if (reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_MASK_HI)) begin
      rd_byte = 8'(pc_mask[1]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_i.read && avs_waitrequest_o) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  sequence s_bus_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_answer: assert property (@(posedge mclk_i) disable iff (reset_i)
    (bus_req && avs_waitrequest_o) |=> s_bus_answer)
    else $error("bus answer not one cycle after request");
  a_irq_gated: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    irq_req_o[epiu_pkg::EPIU_SRC_EXT0] |->
    $past(ext_en[0] && global_int_en_i))
    else $error("request without enable and global bit");
  a_any_change: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (warm && $changed(ext_sync[1]) &&
     sense[epiu_pkg::EPIU_SEL_ONE_LSB +: 2] == epiu_pkg::EPIU_SENSE_ANY)
    |=> ext_flag[1])
    else $error("change on input one missed");
  a_group_irq: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (pc_set[1] && pc_en[1] && global_int_en_i) |=> ##1 irq_req_o[3])
    else $error("upper group request missing");
  a_wake_level: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (ext_en[0] && ext_lvl[0] && !ext_sync[0]) |=> wake_o)
    else $error("low level did not request wake-up");
  a_wake_group: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (|(pc_en & pc_flag)) |=> wake_o)
    else $error("pending group did not request wake-up");
  a_sense_write: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (wr_go && reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_SENSE))
    |=> (sense == $past(wdat[3:0])))
    else $error("sense write not taken");
  a_sense_upper: assert property (
    @(posedge mclk_i) disable iff (reset_i)
    (avs_i.read && avs_waitrequest_o &&
     reg_hit(avs_i.address, epiu_pkg::EPIU_IDX_SENSE))
    |=> (avs_readdata_o[7:4] == 4'h0))
    else $error("reserved sense bits read as set");

endmodule

/* tb/epiu_cpu_model.sv */
// processor side: takes requests and answers with vector entry pulses
// assumes requests are registered on mclk_i and acks last one cycle
`timescale 1ns/1ns
module epiu_cpu_model (
  input wire logic mclk_i, // clock
  input wire logic auto_i, // take vectors when high
  input wire logic [3:0] delay_i, // cycles before vector entry
  input wire logic [3:0] irq_req_i, // request per source
  output logic [3:0] irq_ack_o, // vector entry pulse
  output logic [7:0] n_ack_o // acks given
);
  initial begin
    irq_ack_o = 4'h0;
    n_ack_o = 8'h00;
    forever begin
      @(posedge mclk_i);
      if (auto_i && (irq_req_i != 4'h0)) begin
        repeat (delay_i) @(posedge mclk_i);
        // lowest source first, like a fixed-priority vector table
        irq_ack_o <= irq_req_i & (~irq_req_i + 4'h1);
        n_ack_o <= n_ack_o + 8'h01;
        @(posedge mclk_i);
        irq_ack_o <= 4'h0;
        // request lingers two edges after entry; never take it twice
        repeat (3) @(posedge mclk_i);
      end
    end
  end
endmodule

/* tb/test_ext_pin_interrupt_unit.sv */
// self-checking bench of the external pin interrupt unit
// assumes the design answers on avalon-mm and drives registered requests
`timescale 1ns/1ns
module test_ext_pin_interrupt_unit;
  localparam logic [6:0] SNS = epiu_pkg::EPIU_IDX_SENSE;
  localparam logic [6:0] MLO = epiu_pkg::EPIU_IDX_MASK_LO;
  localparam logic [6:0] MHI = epiu_pkg::EPIU_IDX_MASK_HI;
  localparam logic [6:0] EN = epiu_pkg::EPIU_IDX_EXT_EN;
  localparam logic [6:0] EF = epiu_pkg::EPIU_IDX_EXT_FLAG;
  localparam logic [6:0] PCC = epiu_pkg::EPIU_IDX_PC_CTRL;
  localparam logic [6:0] PF = epiu_pkg::EPIU_IDX_PC_FLAG;
  logic mclk_i, reset_i, gie, auto_ack, wreq, wake;
  epiu_pkg::epiu_avs_req_t avs;
  logic [31:0] rdata, q;
  logic [1:0] ext;
  logic [15:0] pins;
  logic [3:0] ack, req, dly, be;
  logic [7:0] n_ack, nb, mlo, mhi;
  int fails, n_checks, seed;

  epiu_top #(.GROUP_W(8)) epiu_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .avs_i(avs), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .ext_irq_in_zero_i(ext[0]), .ext_irq_in_one_i(ext[1]),
    .pin_change_inputs_i(pins), .global_int_en_i(gie), .irq_ack_i(ack),
    .irq_req_o(req), .wake_o(wake));
  epiu_cpu_model epiu_cpu_model_i (.mclk_i(mclk_i), .auto_i(auto_ack),
    .delay_i(dly), .irq_req_i(req), .irq_ack_o(ack), .n_ack_o(n_ack));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one edge passes first so a release and a new request never share a step
  task automatic bus(input logic w, input logic [6:0] idx,
                     input logic [7:0] d);
    @(posedge mclk_i);
    avs.read <= !w;
    avs.write <= w;
    avs.address <= {idx, 2'b00};
    avs.writedata <= {24'h0, d};
    avs.byteenable <= be;
    // no answer time assumed: only the watchdog ends a wait
    do begin
      @(posedge mclk_i);
    end while (wreq !== 1'b0);
    q = rdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [6:0] idx,
                    input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(what, q, {24'h0, e});
  endtask

  function automatic logic [7:0] fbit(input bit hit, input int n);
    return hit ? 8'(1 << n) : 8'h00;
  endfunction

  function automatic logic [7:0] gexp(input int k);
    logic [15:0] m;
    m = {mhi, mlo};
    return m[k] ? ((k >= 8) ? 8'h02 : 8'h01) : 8'h00;
  endfunction

  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    wt(20000);
    fails++;
    summarize();
  end

  initial begin
    seed = 32'hed6e;
    fails = 0;
    n_checks = 0;
    reset_i = 1'b1;
    avs = '0;
    ext = 2'h3;
    pins = 16'h0000;
    gie = 1'b0;
    auto_ack = 1'b0;
    dly = 4'h0;
    be = 4'h1;
    wt(16);
    reset_i <= 1'b0;
    wt(4);
    for (int i = 0; i < 8; i++) rd("reset", SNS + 7'(i), 8'h00);
    bus(1'b1, SNS, 8'hFF);
    rd("sense", SNS, 8'h0F);
    bus(1'b1, EN, 8'hFF);
    rd("enable", EN, 8'h03);
    bus(1'b1, PCC, 8'hFF);
    rd("grp enable", PCC, 8'h03);
    be = 4'h2;
    bus(1'b1, SNS, 8'h00);
    be = 4'h1;
    rd("lane refused", SNS, 8'h0F);
    bus(1'b1, 7'h6A, 8'hFF);
    rd("unmapped", 7'h6A, 8'h00);
    $display("test registers done");
    gie <= 1'b1;
    for (int n = 0; n < 2; n++) begin
      for (int m = 1; m < 4; m++) begin
        bus(1'b1, SNS, 8'(m << (2 * n)));
        bus(1'b1, EF, 8'h03);
        ext[n] <= 1'b0;
        wt(6 + ($random(seed) & 3));
        rd("fall flag", EF, fbit(m != 3, n));
        chk("fall req", req[n], m != 3);
        bus(1'b1, EF, 8'h03);
        rd("w1c", EF, 8'h00);
        ext[n] <= 1'b1;
        wt(6);
        rd("rise flag", EF, fbit(m != 2, n));
        bus(1'b1, EF, 8'h03);
      end
    end
    bus(1'b1, SNS, {6'h0, epiu_pkg::EPIU_SENSE_FALL});
    bus(1'b1, EF, 8'h03);
    ext[0] <= 1'b0;
    wt(2);
    ext[0] <= 1'b1;
    wt(6);
    rd("short pulse", EF, 8'h01);
    $display("test sense done");
    bus(1'b1, SNS, 8'h00);
    ext[0] <= 1'b0;
    wt(6);
    chk("level req", req[0], 1'b1);
    rd("level flag", EF, 8'h00);
    gie <= 1'b0;
    wt(3);
    chk("global off", req[0], 1'b0);
    chk("wake", wake, 1'b1);
    ext[0] <= 1'b1;
    gie <= 1'b1;
    wt(6);
    chk("level gone", req[0], 1'b0);
    $display("test level done");
    bus(1'b1, EN, 8'h00);
    mlo = 8'($random(seed));
    mhi = 8'($random(seed));
    bus(1'b1, MLO, mlo);
    bus(1'b1, MHI, mhi);
    rd("mask", MHI, mhi);
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, PF, 8'h03);
      pins[k] <= ~pins[k];
      wt(6);
      rd("group flag", PF, gexp(k));
    end
    $display("test groups done");
    bus(1'b1, MLO, 8'hFF);
    bus(1'b1, MHI, 8'hFF);
    bus(1'b1, PF, 8'h03);
    wt(3);
    nb = n_ack;
    dly <= 4'($random(seed) & 3);
    auto_ack <= 1'b1;
    pins <= pins ^ 16'h1008;
    wt(30);
    chk("acks", n_ack - nb, 8'h02);
    chk("req after ack", req, 4'h0);
    rd("flag after ack", PF, 8'h00);
    bus(1'b1, PCC, 8'h00);
    pins[0] <= ~pins[0];
    wt(6);
    chk("group off", req, 4'h0);
    rd("flag kept", PF, 8'h01);
    bus(1'b1, SNS, {6'h0, epiu_pkg::EPIU_SENSE_FALL});
    bus(1'b1, EN, 8'h01);
    bus(1'b1, EF, 8'h03);
    nb = n_ack;
    ext[0] <= 1'b0;
    wt(20);
    chk("ext acks", n_ack - nb, 8'h01);
    rd("ext flag after ack", EF, 8'h00);
    chk("ext req after ack", req, 4'h0);
    ext[0] <= 1'b1;
    $display("test vectors done");
    summarize();
  end
endmodule
